/* File: src/ecp_params.svh */
// Register offsets, field positions, reset values and timing counts of the PWM control block.
// Assumes a 32-bit Avalon-MM slave with word-aligned registers.
`ifndef ECP_PARAMS_SVH
`define ECP_PARAMS_SVH
`define ECP_OFF_MODE 4'h0
`define ECP_OFF_SHUT 4'h4
`define ECP_OFF_DBND 4'h8
`define ECP_OFF_STEER 4'hC
`define ECP_OFF_DUTY 5'h10
`define ECP_OFF_PERIOD 5'h14
`define ECP_OFF_STATUS 5'h18
`define ECP_RST_MODE 8'h00
`define ECP_RST_SHUT 8'h00
`define ECP_RST_DBND 8'h00
`define ECP_RST_STEER 8'h01
`define ECP_RST_DUTY 8'h00
`define ECP_RST_PERIOD 8'hFF
`define ECP_STEER_MASK 8'h13
`define ECP_SHUT_STATUS_BIT 7
`define ECP_TCY_CLOCKS 2'h3
`endif

/* File: src/ecp_pkg.sv */
// Types shared by the PWM control block.
// Assumes the parameter header is included by the design file.
package ecp_pkg;
	typedef struct packed {
		logic [1:0] config_sel;
		logic [1:0] duty_low_bits;
		logic [3:0] unit_mode_select;
	} ecp_mode_t;
	typedef struct packed {
		logic shutdown_status;
		logic [2:0] shutdown_source_select;
		logic [1:0] first_pin_shutdown_state;
		logic [1:0] second_pin_shutdown_state;
	} ecp_shut_t;
	typedef struct packed {
		logic out;
		logic oe;
	} ecp_pin_t;
	typedef enum logic [1:0] {ECP_OFF, ECP_CAPTURE, ECP_COMPARE, ECP_PWM} ecp_func_t;
endpackage

/* File: src/ecp_pwm_ctrl.sv */
// Enhanced capture/compare/PWM control with dead band, auto-shutdown and steering.
// Assumes the period timer is internal; compare match, capture pin, comparator and fault pin
// arrive as inputs; pins and comparator are asynchronous and are synchronised here.
// How it works
// [RULE_01] Mode zero switches the unit off and clears its internal state.
// [RULE_02] Capture on falling, rising, every fourth or every sixteenth rising edge.
// [RULE_03] Compare 1000 starts low going high; 1001 starts high going low; flag set.
// [RULE_04] Compare 1010 only raises the flag and frees the primary pin.
// [RULE_05] Compare 0010 toggles the primary output on each match.
// [RULE_06] Compare 1011 resets the timer, raises the flag and starts a conversion.
// [RULE_07] Upper mode bits 11 select PWM; low bits set each output polarity.
// [RULE_08] Config 00 drives first output only; 10 is a dead-banded half-bridge.
// [RULE_09] Outside PWM the first pin is capture/compare, the second a port pin.
// [RULE_10] Duty is ten bits: duty register high, control bits five and four low.
// [RULE_11] Shutdown status reads one while outputs are held in shutdown.
// [RULE_12] Source field picks comparator low, fault pin low, or either.
// [RULE_13] First pin shutdown state: tri-state, drive high or drive low.
// [RULE_14] Second pin shutdown state chosen the same way, independently.
// [RULE_15] With comparator sync enabled, comparator shutdown waits for the sync timer.
// [RULE_16] With auto-restart, status clears itself when the trigger goes away.
// [RULE_17] Without auto-restart, software clears the status to resume.
// [RULE_18] Delay count sets instruction cycles before an active transition.
// [RULE_19] Steering sync defers steering changes to the next PWM period.
// [RULE_20] Each steering bit routes the waveform to its pin or frees it.
// [RULE_21] Steering acts only in PWM mode with single output configuration.
// [RULE_22] Software keeps the reserved steering bits at zero.
// [RULE_23] Shutdown trigger is a level; status writes are ignored while it stands.
// [RULE_24] Shutdown forces the enabled pins without waiting for a clock edge; here they are forced from flops, two clocks after the trigger.
// [RULE_25] After shutdown the waveform resumes at the start of the next period.
// [RULE_26] In steering mode shutdown touches only steered pins.
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`include "ecp_params.svh"
module ecp_pwm_ctrl (
	input wire logic clock,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic capture_pin,
	input wire logic fault_input_pin,
	input wire logic comparator_out,
	input wire logic comparator_sync_enable,
	input wire logic sync_timer_tick,
	input wire logic compare_match,
	input wire logic adc_enabled,
	output logic unit_interrupt_flag,
	output logic capture_strobe,
	output logic timer_reset,
	output logic adc_start,
	output logic first_pwm_output,
	output logic first_pwm_oe,
	output logic second_pwm_output,
	output logic second_pwm_oe
);
	ecp_pkg::ecp_mode_t mode_q;
	ecp_pkg::ecp_shut_t shut_q;
	logic [7:0] dbnd_q, steer_q, steer_live_q, duty_q, duty_live_q, period_q;
	logic [1:0] dlow_live_q;
	logic acc_q;
	logic [1:0] cap_s_q, flt_s_q, cmp_s_q;
	logic cap_prev_q, cmp_held_q;
	logic [3:0] cap_cnt_q;
	logic [7:0] tmr_q;
	logic [1:0] tcy_q;
	logic [9:0] frac_q;
	logic pwm_raw_q, cmp_out_q, hold_q;
	logic [8:0] dly_a_q, dly_b_q;
	logic pa_q, pb_q;
	ecp_pkg::ecp_pin_t pin_a, pin_b;
	ecp_pkg::ecp_pin_t pin_a_q, pin_b_q;
	ecp_pkg::ecp_func_t func;
	logic wr, rd, trig, period_start, cap_edge, single, steer_en;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic ecp_pkg::ecp_func_t decode_mode(input logic [3:0] m);
		if (m == 4'h0) begin
			return ecp_pkg::ECP_OFF;
		end else if (m[3:2] == 2'h3) begin
			return ecp_pkg::ECP_PWM;
		end else if (m[3:2] == 2'h1) begin
			return ecp_pkg::ECP_CAPTURE;
		end else begin
			return ecp_pkg::ECP_COMPARE;
		end
	endfunction

	// Upper state bit releases the pin; the lower one is the level driven otherwise.
	function automatic ecp_pkg::ecp_pin_t shut_pin(input logic [1:0] st);
		return '{out: st[0], oe: ~st[1]};
	endfunction

	assign func = decode_mode(mode_q.unit_mode_select);
	// A write lands only at the edge at which the master sees waitrequest low.
	assign wr = avs_write && acc_q;
	assign rd = avs_read && !acc_q;
	assign single = func == ecp_pkg::ECP_PWM && mode_q.config_sel == 2'h0;
	assign steer_en = single; // RULE_21

	// ****************************************
	// Avalon slave: one wait cycle per access
	// ****************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc_q <= 1'b0;
		end else begin
			acc_q <= (avs_read || avs_write) && !acc_q;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_q <= `ECP_RST_MODE;
			dbnd_q <= `ECP_RST_DBND;
			steer_q <= `ECP_RST_STEER;
			duty_q <= `ECP_RST_DUTY;
			period_q <= `ECP_RST_PERIOD;
		end else if (wr && avs_byteenable[0]) begin
			case (avs_address)
				`ECP_OFF_MODE: mode_q <= avs_writedata[7:0];
				`ECP_OFF_DBND: dbnd_q <= avs_writedata[7:0];
				`ECP_OFF_STEER: steer_q <= avs_writedata[7:0] & `ECP_STEER_MASK;
				`ECP_OFF_DUTY: duty_q <= avs_writedata[7:0];
				`ECP_OFF_PERIOD: period_q <= avs_writedata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0;
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && !acc_q);
			avs_readdata <= 32'h0;
			if (rd) begin
				case (avs_address)
					`ECP_OFF_MODE: avs_readdata <= {24'h0, mode_q};
					`ECP_OFF_SHUT: avs_readdata <= {24'h0, shut_q}; // RULE_11
					`ECP_OFF_DBND: avs_readdata <= {24'h0, dbnd_q};
					`ECP_OFF_STEER: avs_readdata <= {24'h0, steer_q};
					`ECP_OFF_DUTY: avs_readdata <= {24'h0, duty_q};
					`ECP_OFF_PERIOD: avs_readdata <= {24'h0, period_q};
					`ECP_OFF_STATUS: avs_readdata <= {28'h0, tmr_q[0], pwm_raw_q, hold_q,
						unit_interrupt_flag};
					default: avs_readdata <= 32'h0;
				endcase
			end
		end
	end

	// ****************************************
	// Input synchronisers
	// ****************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cap_s_q <= 2'h0;
			flt_s_q <= 2'h3;
			cmp_s_q <= 2'h3;
		end else begin
			cap_s_q <= {cap_s_q[0], capture_pin};
			flt_s_q <= {flt_s_q[0], fault_input_pin};
			cmp_s_q <= {cmp_s_q[0], comparator_out};
		end
	end

	// ****************************************
	// Capture and compare
	// ****************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cap_prev_q <= 1'b0;
		end else begin
			cap_prev_q <= cap_s_q[1];
		end
	end

	// RULE_02
	assign cap_edge = mode_q.unit_mode_select == 4'h4 ? (cap_prev_q && !cap_s_q[1])
		: (!cap_prev_q && cap_s_q[1]);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cap_cnt_q <= 4'h0;
			capture_strobe <= 1'b0;
		end else if (func != ecp_pkg::ECP_CAPTURE) begin
			cap_cnt_q <= 4'h0; // RULE_01
			capture_strobe <= 1'b0;
		end else begin
			capture_strobe <= 1'b0;
			if (cap_edge) begin
				cap_cnt_q <= cap_cnt_q + 4'h1;
				case (mode_q.unit_mode_select[1:0])
					2'h2: capture_strobe <= cap_cnt_q[1:0] == 2'h3; // RULE_02
					2'h3: capture_strobe <= cap_cnt_q == 4'hF; // RULE_02
					default: capture_strobe <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cmp_out_q <= 1'b0;
			unit_interrupt_flag <= 1'b0;
			timer_reset <= 1'b0;
			adc_start <= 1'b0;
		end else begin
			timer_reset <= 1'b0;
			adc_start <= 1'b0;
			// The flag pulses once per event; the interrupt flag register lives elsewhere.
			unit_interrupt_flag <= capture_strobe;
			if (wr && avs_byteenable[0] && avs_address == `ECP_OFF_MODE) begin
				cmp_out_q <= avs_writedata[3:0] == 4'h9; // RULE_03
			end else if (func != ecp_pkg::ECP_COMPARE) begin
				cmp_out_q <= 1'b0; // RULE_01
			end else if (compare_match) begin
				case (mode_q.unit_mode_select)
					4'h2: cmp_out_q <= ~cmp_out_q; // RULE_05
					4'h8: cmp_out_q <= 1'b1; // RULE_03
					4'h9: cmp_out_q <= 1'b0; // RULE_03
					default: ;
				endcase
				unit_interrupt_flag <= mode_q.unit_mode_select[3]; // RULE_03 RULE_04
				timer_reset <= mode_q.unit_mode_select == 4'hB; // RULE_06
				adc_start <= mode_q.unit_mode_select == 4'hB && adc_enabled; // RULE_06
			end
		end
	end

	// ****************************************
	// Period timer and PWM waveform
	// ****************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tcy_q <= 2'h0;
			tmr_q <= 8'h0;
			frac_q <= 10'h0;
		end else if (func != ecp_pkg::ECP_PWM) begin
			tcy_q <= 2'h0;
			tmr_q <= 8'h0;
			frac_q <= 10'h0;
		end else begin
			tcy_q <= tcy_q + 2'h1;
			frac_q <= period_start ? 10'h0 : frac_q + 10'h1;
			if (tcy_q == `ECP_TCY_CLOCKS) begin
				tmr_q <= tmr_q == period_q ? 8'h0 : tmr_q + 8'h1;
			end
		end
	end

	assign period_start = tcy_q == `ECP_TCY_CLOCKS && tmr_q == period_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pwm_raw_q <= 1'b0;
			duty_live_q <= 8'h0;
			dlow_live_q <= 2'h0;
		end else if (func != ecp_pkg::ECP_PWM) begin
			pwm_raw_q <= 1'b0;
		end else if (period_start) begin
			duty_live_q <= duty_q; // RULE_10
			dlow_live_q <= mode_q.duty_low_bits; // RULE_10
			pwm_raw_q <= {duty_q, mode_q.duty_low_bits} != 10'h0;
		end else if (frac_q + 10'h1 >= {duty_live_q, dlow_live_q}) begin
			pwm_raw_q <= 1'b0; // RULE_10
		end
	end

	// Dead band delays only the rise of each half-bridge leg. It is counted in clocks,
	// four per instruction cycle, so both legs get the same delay whatever the phase.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dly_a_q <= 9'h0;
			dly_b_q <= 9'h0;
			pa_q <= 1'b0;
			pb_q <= 1'b0;
		end else begin
			if (!pwm_raw_q || mode_q.config_sel != 2'h2) begin
				dly_a_q <= 9'h0;
				pa_q <= pwm_raw_q;
			end else if (dly_a_q < {dbnd_q[6:0], 2'h0}) begin
				dly_a_q <= dly_a_q + 9'h1; // RULE_18
			end else begin
				pa_q <= 1'b1; // RULE_18
			end
			if (pwm_raw_q) begin
				dly_b_q <= 9'h0;
				pb_q <= 1'b0;
			end else if (dly_b_q < {dbnd_q[6:0], 2'h0}) begin
				dly_b_q <= dly_b_q + 9'h1; // RULE_18
			end else begin
				pb_q <= 1'b1; // RULE_18
			end
		end
	end

	// ****************************************
	// Auto-shutdown and steering
	// ****************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cmp_held_q <= 1'b0;
		end else if (!comparator_sync_enable || sync_timer_tick) begin
			cmp_held_q <= !cmp_s_q[1]; // RULE_15
		end
	end

	// RULE_12 RULE_23
	always_comb begin
		case (shut_q.shutdown_source_select)
			3'h1, 3'h3: trig = cmp_held_q;
			3'h4: trig = !flt_s_q[1];
			3'h5, 3'h7: trig = cmp_held_q || !flt_s_q[1];
			default: trig = 1'b0;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			shut_q <= `ECP_RST_SHUT;
		end else begin
			if (wr && avs_byteenable[0] && avs_address == `ECP_OFF_SHUT) begin
				shut_q[6:0] <= avs_writedata[6:0];
				if (!trig) begin
					shut_q.shutdown_status <= avs_writedata[`ECP_SHUT_STATUS_BIT]; // RULE_17
				end
			end
			if (trig) begin
				shut_q.shutdown_status <= 1'b1; // RULE_23
			end else if (dbnd_q[7] && !(wr && avs_address == `ECP_OFF_SHUT)) begin
				shut_q.shutdown_status <= 1'b0; // RULE_16
			end
			if (func == ecp_pkg::ECP_OFF) begin
				shut_q.shutdown_status <= 1'b0; // RULE_01
			end
		end
	end

	// Holds the pins in their shutdown state until a period boundary after release.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hold_q <= 1'b0;
		end else if (shut_q.shutdown_status || trig) begin
			hold_q <= 1'b1;
		end else if (period_start || func != ecp_pkg::ECP_PWM) begin
			hold_q <= 1'b0; // RULE_25
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			steer_live_q <= `ECP_RST_STEER;
		end else if (!steer_q[4] || period_start) begin
			steer_live_q <= steer_q; // RULE_19
		end
	end

	// Pin composition ahead of the output flops.
	always_comb begin
		pin_a = '{out: 1'b0, oe: 1'b0};
		pin_b = '{out: 1'b0, oe: 1'b0};
		case (func)
			ecp_pkg::ECP_PWM: begin
				pin_a.out = pa_q ^ mode_q.unit_mode_select[1]; // RULE_07
				pin_b.out = pb_q ^ mode_q.unit_mode_select[0]; // RULE_07
				if (steer_en) begin
					pin_a.oe = steer_live_q[0]; // RULE_20
					pin_b.oe = steer_live_q[1]; // RULE_20
					pin_b.out = pa_q ^ mode_q.unit_mode_select[0];
				end else begin
					pin_a.oe = mode_q.config_sel == 2'h0 || mode_q.config_sel == 2'h2; // RULE_08
					pin_b.oe = mode_q.config_sel == 2'h2; // RULE_08
				end
				if (hold_q) begin
					if (pin_a.oe) begin
						pin_a = shut_pin(shut_q.first_pin_shutdown_state); // RULE_13 RULE_26
					end
					if (pin_b.oe) begin
						pin_b = shut_pin(shut_q.second_pin_shutdown_state); // RULE_14 RULE_26
					end
				end
			end
			ecp_pkg::ECP_COMPARE: begin
				pin_a.out = cmp_out_q; // RULE_09
				pin_a.oe = mode_q.unit_mode_select != 4'hA; // RULE_04
			end
			default: ;
		endcase
	end

	// Outputs leave flops; a level trigger forces the enabled pins two cycles later.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_a_q <= '{out: 1'b0, oe: 1'b0};
			pin_b_q <= '{out: 1'b0, oe: 1'b0};
		end else begin
			pin_a_q <= pin_a; // RULE_24
			pin_b_q <= pin_b;
		end
	end

	assign first_pwm_output = pin_a_q.out;
	assign first_pwm_oe = pin_a_q.oe;
	assign second_pwm_output = pin_b_q.out;
	assign second_pwm_oe = pin_b_q.oe;
endmodule

/* File: testbench/ecp_bridge_model.sv */
// Model of the half-bridge switch inputs and the fault source beside the PWM block.
// Assumes pull-downs on both switch inputs and a fault line that is a plain level.
module ecp_bridge_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic fault_req,
	input wire logic cmp_req,
	input wire logic first_pwm_output,
	input wire logic first_pwm_oe,
	input wire logic second_pwm_output,
	input wire logic second_pwm_oe,
	output logic fault_input_pin,
	output logic comparator_out,
	output logic sync_timer_tick,
	output logic first_leg,
	output logic second_leg
);
	logic [2:0] tick_q;
	// A released pin falls to its pull-down, so a switch stays off rather than floating.
	assign first_leg = first_pwm_oe ? first_pwm_output : 1'b0;
	assign second_leg = second_pwm_oe ? second_pwm_output : 1'b0;
	assign fault_input_pin = !fault_req;
	assign comparator_out = !cmp_req;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tick_q <= 3'h0;
		end else begin
			tick_q <= tick_q + 3'h1;
		end
	end
	assign sync_timer_tick = tick_q == 3'h7;
endmodule

/* File: testbench/ecp_pwm_ctrl_chk.sv */
// Assertion checker for the PWM control block, bound to its top module.
// Assumes byte lane zero is always enabled, so every accepted write lands.
`include "ecp_params.svh"
module ecp_pwm_ctrl_chk (
	input wire logic clock,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic fault_input_pin,
	input wire logic adc_enabled,
	input wire logic compare_match,
	input wire logic unit_interrupt_flag,
	input wire logic timer_reset,
	input wire logic adc_start,
	input wire logic first_pwm_output,
	input wire logic first_pwm_oe,
	input wire logic second_pwm_oe
);
	// ********
	// Register shadows and settle counters
	// ********
	logic [7:0] mode_q;
	logic [6:0] shut_q;
	logic [1:0] steer_q;
	logic [2:0] flt_q, age_q;
	logic wr_ok, shut_on;
	assign wr_ok = avs_write && !avs_waitrequest;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_q <= 8'h00;
			shut_q <= 7'h00;
			steer_q <= 2'h1;
		end else if (wr_ok && avs_address == 5'(`ECP_OFF_MODE)) begin
			mode_q <= avs_writedata[7:0];
		end else if (wr_ok && avs_address == 5'(`ECP_OFF_SHUT)) begin
			shut_q <= avs_writedata[6:0];
		end else if (wr_ok && avs_address == 5'(`ECP_OFF_STEER)) begin
			steer_q <= avs_writedata[1:0];
		end
	end
	// Pin forcing lags the pin synchroniser and any write, so judge it only once both settle.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flt_q <= 3'h0;
			age_q <= 3'h0;
		end else begin
			flt_q <= fault_input_pin ? 3'h0 : flt_q + 3'(flt_q != 3'h7);
			age_q <= wr_ok ? 3'h0 : age_q + 3'(age_q != 3'h7);
		end
	end
	assign shut_on = flt_q == 3'h7 && age_q == 3'h7 && shut_q[6:4] == 3'h4 &&
		mode_q[7:6] == 2'h0 && mode_q[3:2] == 2'h3;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_steer_rsvd: assert property (
		avs_read && !avs_waitrequest && avs_address == 5'(`ECP_OFF_STEER)
		|-> (avs_readdata[7:0] & 8'hEC) == 8'h00) else $error("reserved steering bits read set");
	a_off_quiet: assert property (
		mode_q[3:0] == 4'h0 [*3] |-> !first_pwm_oe && !second_pwm_oe)
		else $error("pins driven while unit off");
	a_second_port: assert property (
		mode_q[3:2] != 2'h3 [*3] |-> !second_pwm_oe) else $error("second pin driven outside pwm");
	a_match_flag: assert property (
		compare_match && mode_q[3:2] == 2'h2 |=> unit_interrupt_flag) else $error("no match flag");
	a_set_high: assert property (
		compare_match && mode_q[3:0] == 4'h8 |-> ##2 first_pwm_output)
		else $error("match did not set pin");
	a_toggle_out: assert property (
		compare_match && mode_q[3:0] == 4'h2 |-> ##2 first_pwm_output != $past(first_pwm_output, 2))
		else $error("match did not toggle pin");
	a_special_evt: assert property (
		compare_match && adc_enabled && mode_q[3:0] == 4'hB |=> timer_reset && adc_start)
		else $error("special event pulses missing");
	a_shut_first: assert property (
		shut_on |-> first_pwm_oe == (steer_q[0] && !shut_q[3])) else $error("first pin enable wrong");
	a_shut_level: assert property (
		shut_on && first_pwm_oe |-> first_pwm_output == shut_q[2]) else $error("first pin level wrong");
	a_shut_second: assert property (
		shut_on |-> second_pwm_oe == (steer_q[1] && !shut_q[1])) else $error("second pin enable wrong");
endmodule
bind ecp_pwm_ctrl ecp_pwm_ctrl_chk i_chk (
	.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
	.avs_waitrequest, .fault_input_pin, .adc_enabled, .compare_match, .unit_interrupt_flag,
	.timer_reset, .adc_start, .first_pwm_output, .first_pwm_oe, .second_pwm_oe
);

/* File: testbench/ecp_pwm_ctrl_tb.sv */
// Self-checking bench of the PWM control block with the bridge model on its pins.
// Assumes one wait cycle per Avalon access and outputs registered on the clock.
`include "ecp_params.svh"
module ecp_pwm_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, rst, avs_read, avs_write, avs_waitrequest, capture_pin, compare_match, fault_req;
	logic comparator_out, comparator_sync_enable, sync_timer_tick, adc_enabled, fault_input_pin;
	logic unit_interrupt_flag, capture_strobe, timer_reset, adc_start, first_leg, second_leg;
	logic first_pwm_output, first_pwm_oe, second_pwm_output, second_pwm_oe, cmp_req;
	logic [4:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata;
	int n_mismatch, num_checks, cyc;
	ecp_pwm_ctrl i_dut (
		.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .capture_pin, .fault_input_pin, .comparator_out,
		.comparator_sync_enable, .sync_timer_tick, .compare_match, .adc_enabled,
		.unit_interrupt_flag, .capture_strobe, .timer_reset, .adc_start, .first_pwm_output,
		.first_pwm_oe, .second_pwm_output, .second_pwm_oe
	);
	ecp_bridge_model i_bridge (
		.clock, .rst, .fault_req, .cmp_req, .first_pwm_output, .first_pwm_oe, .second_pwm_output,
		.second_pwm_oe, .fault_input_pin, .comparator_out, .sync_timer_tick, .first_leg,
		.second_leg
	);
	// ********
	// Shared tasks
	// ********
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= 1'b1;
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd_chk(input string what, input logic [4:0] a, input logic [7:0] exp);
		logic [7:0] got;
		avs_address <= a;
		avs_read <= 1'b1;
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		got = avs_readdata[7:0];
		avs_read <= 1'b0;
		@(posedge clock);
		chk(what, exp, got);
	endtask
	task automatic count_legs(output int a, output int b);
		a = 0;
		b = 0;
		repeat (16) begin
			@(negedge clock);
			a += first_leg;
			b += second_leg;
		end
		@(posedge clock);
	endtask
	// ********
	// Scenarios
	// ********
	task automatic t_regs();
		rd_chk("mode reset", `ECP_OFF_MODE, 8'h00);
		rd_chk("shutdown reset", `ECP_OFF_SHUT, 8'h00);
		rd_chk("deadband reset", `ECP_OFF_DBND, 8'h00);
		rd_chk("steering reset", `ECP_OFF_STEER, 8'h01);
		bus_wr(`ECP_OFF_STEER, 8'hF3);
		rd_chk("steering masked", `ECP_OFF_STEER, 8'h13);
		bus_wr(5'h1C, 8'hA5);
		rd_chk("unmapped", 5'h1C, 8'h00);
	endtask
	task automatic t_compare();
		for (int m = 8; m < 12; m++) begin
			bus_wr(`ECP_OFF_MODE, 8'(m));
			repeat (3) @(negedge clock);
			if (m < 10) begin
				chk("initial level", m == 9, first_pwm_output);
			end
			@(posedge clock);
			compare_match <= 1'b1;
			@(posedge clock);
			compare_match <= 1'b0;
			@(negedge clock);
			chk("match flag", 1, unit_interrupt_flag);
			if (m == 10) begin
				chk("pin freed", 0, first_pwm_oe);
			end else if (m == 11) begin
				chk("event pulses", 2'b11, {timer_reset, adc_start});
			end
			// The pin follows the compare latch one registered stage later.
			@(negedge clock);
			if (m < 10) begin
				chk("level after match", m == 8, first_pwm_output);
			end
			@(posedge clock);
		end
		bus_wr(`ECP_OFF_MODE, 8'h02);
		repeat (2) begin
			compare_match <= 1'b1;
			@(posedge clock);
			compare_match <= 1'b0;
			repeat (2) @(posedge clock);
		end
		bus_wr(`ECP_OFF_MODE, 8'h00);
		repeat (3) @(negedge clock);
		chk("unit off", 2'b00, {first_pwm_oe, second_pwm_oe});
		@(posedge clock);
	endtask
	task automatic t_capture();
		int n;
		for (int m = 4; m < 8; m++) begin
			n = 0;
			bus_wr(`ECP_OFF_MODE, 8'h00);
			bus_wr(`ECP_OFF_MODE, 8'(m));
			for (int k = 0; k < 136; k++) begin
				capture_pin <= (k < 128) && k[2];
				@(negedge clock);
				n += capture_strobe;
				@(posedge clock);
			end
			chk("capture count", (m < 6) ? 16 : ((m == 6) ? 4 : 1), n);
		end
	endtask
	task automatic t_pwm();
		logic [7:0] md [4] = '{8'h2C, 8'h2F, 8'hAC, 8'h2C};
		logic [7:0] st [4] = '{8'h01, 8'h01, 8'h01, 8'h02};
		int ea [4] = '{10, 6, 6, 0};
		int eb [4] = '{0, 0, 2, 10};
		int a, b;
		bus_wr(`ECP_OFF_PERIOD, 8'h03);
		bus_wr(`ECP_OFF_DUTY, 8'h02);
		bus_wr(`ECP_OFF_DBND, 8'h01);
		for (int i = 0; i < 4; i++) begin
			bus_wr(`ECP_OFF_STEER, st[i]);
			bus_wr(`ECP_OFF_MODE, md[i]);
			repeat (40) @(posedge clock);
			count_legs(a, b);
			chk("first leg", ea[i], a);
			chk("second leg", eb[i], b);
		end
	endtask
	task automatic t_shutdown();
		int a, b;
		bus_wr(`ECP_OFF_STEER, 8'h03);
		bus_wr(`ECP_OFF_MODE, 8'h2C);
		bus_wr(`ECP_OFF_SHUT, 8'h06);
		fault_req <= 1'b1;
		repeat (10) @(posedge clock);
		rd_chk("source off", `ECP_OFF_SHUT, 8'h06);
		bus_wr(`ECP_OFF_SHUT, 8'h46);
		repeat (10) @(negedge clock);
		chk("first forced", 2'b11, {first_pwm_oe, first_pwm_output});
		chk("second forced", 0, second_pwm_oe);
		@(posedge clock);
		rd_chk("status set", `ECP_OFF_SHUT, 8'hC6);
		bus_wr(`ECP_OFF_SHUT, 8'h46);
		rd_chk("status held", `ECP_OFF_SHUT, 8'hC6);
		fault_req <= 1'b0;
		repeat (40) @(posedge clock);
		rd_chk("status kept", `ECP_OFF_SHUT, 8'hC6);
		bus_wr(`ECP_OFF_SHUT, 8'h46);
		rd_chk("status cleared", `ECP_OFF_SHUT, 8'h46);
		bus_wr(`ECP_OFF_STEER, 8'h01);
		bus_wr(`ECP_OFF_SHUT, 8'h41);
		bus_wr(`ECP_OFF_DBND, 8'h81);
		fault_req <= 1'b1;
		repeat (10) @(negedge clock);
		chk("first low", 2'b10, {first_pwm_oe, first_pwm_output});
		chk("unsteered pin", 0, second_pwm_oe);
		@(posedge clock);
		fault_req <= 1'b0;
		repeat (40) @(posedge clock);
		rd_chk("auto restart", `ECP_OFF_SHUT, 8'h41);
		count_legs(a, b);
		chk("resumed", 10, a);
		bus_wr(`ECP_OFF_SHUT, 8'h11);
		comparator_sync_enable <= 1'b1;
		do begin
			@(posedge clock);
		end while (sync_timer_tick !== 1'b1);
		cmp_req <= 1'b1;
		// The next sync tick is eight clocks away, so the trip must not show yet.
		repeat (4) @(posedge clock);
		rd_chk("sync delays trip", `ECP_OFF_SHUT, 8'h11);
		repeat (8) @(posedge clock);
		rd_chk("comparator trip", `ECP_OFF_SHUT, 8'h91);
		cmp_req <= 1'b0;
		repeat (20) @(posedge clock);
		rd_chk("comparator restart", `ECP_OFF_SHUT, 8'h11);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always #10 clock = ~clock;
	// The whole run needs about 1100 cycles; the ceiling leaves ample margin.
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	initial begin
		clock = 1'b0;
		rst = 1'b1;
		{avs_read, avs_write, capture_pin, compare_match, fault_req, cmp_req} = 6'h00;
		comparator_sync_enable = 1'b0;
		adc_enabled = 1'b1;
		avs_byteenable = 4'h1;
		avs_address = 5'h00;
		avs_writedata = 32'h00000000;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		t_regs();
		t_compare();
		t_capture();
		t_pwm();
		t_shutdown();
		close_out();
	end
endmodule
